// >>> rtl/sarlc_map.svh
// What this block does
// - serial data changes on each output clock rise, most significant bit first
// - frame is 16 output clocks with byte select low, 8 when high
// - frame sync rising edges mark frame boundaries
// - chip select high floats data and sync, output clock stays driven
// - both conversion-start inputs act identically; unused one held at 0
// - power-down input low powers down, high runs normally
// - nap select high: nap after conversion end until next acquisition
// - topology select 1 means cascade, 0 means daisy chain
// - clock source select 1 uses internal clock, 0 external clock input
// - latency select 1 reads with latency, 0 without
// - busy is high exactly while a conversion runs
// - read request low asks for data; also the chain handshake
// - bus-in-use shows the device owns the shared serial bus
// - cascade: output clock driven when clock-drive select 1, floated when 0
// - read request fall, chip select low, wait, sample or nap: start read
// - msb on second clock rise after sync rise, then one per rise
// - start-convert rise starts sampling, fall starts conversion
// - start-convert fall during conversion aborts it; data becomes invalid
`ifndef SARLC_MAP_SVH
`define SARLC_MAP_SVH

`define SARLC_CLK_PERIOD_NS 8
`define SARLC_CONV_TIME_NS 400
`define SARLC_CONV_CYCLES ((`SARLC_CONV_TIME_NS + `SARLC_CLK_PERIOD_NS - 1) / `SARLC_CLK_PERIOD_NS)
`define SARLC_INT_CLK_HALF 1
`define SARLC_WORD_BITS 16
`define SARLC_FRAME_LONG 5'h10
`define SARLC_FRAME_BYTE 5'h08
`define SARLC_MSB_EDGE 5'h02
`define SARLC_LAST_EDGE 5'h11
`define SARLC_DONE_EDGE 5'h12
`define SARLC_WORD_RESET 16'h0000

`endif

// >>> rtl/sarlc_pkg.sv
package sarlc_pkg;

    typedef struct packed {
        logic conv_cmos_n;
        logic conv_lvds_n;
        logic cs_n;
        logic byte_sel;
        logic pd_n;
        logic nap_sel;
        logic cascade;
        logic clk_int;
        logic latency;
        logic rd_n;
        logic clk_drive;
        logic ext_clk;
        logic chain_d;
        logic chain_f;
    } sarlc_pins_t;

    typedef enum logic [2:0] {
        PH_WAIT,
        PH_SAMPLE,
        PH_CONV,
        PH_NAP,
        PH_DOWN
    } sarlc_phase_t;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_SEND,
        RD_FWD
    } sarlc_read_t;

endpackage

// >>> rtl/sarlc_ctrl.sv
`timescale 1ns/1ns
`include "sarlc_map.svh"

module sarlc_ctrl #(
    parameter int unsigned CONV_CYCLES = `SARLC_CONV_CYCLES,
    parameter int unsigned INT_HALF = `SARLC_INT_CLK_HALF
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic convert_start_cmos_n_i,
    input wire logic convert_start_lvds_n_i,
    input wire logic chip_select_n_i,
    input wire logic byte_frame_sel_i,
    input wire logic power_down_n_i,
    input wire logic nap_sel_i,
    input wire logic topology_sel_i,
    input wire logic clock_source_sel_i,
    input wire logic read_latency_sel_i,
    input wire logic read_request_n_i,
    input wire logic cascade_clock_drive_sel_i,
    input wire logic ext_clock_i,
    input wire logic chain_data_in_i,
    input wire logic chain_frame_in_i,
    input wire logic [`SARLC_WORD_BITS-1:0] sample_data_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_n_o,
    output logic frame_sync_o,
    output logic frame_sync_oe_n_o,
    output logic out_clock_o,
    output logic out_clock_oe_n_o,
    output logic busy_o,
    output logic bus_in_use_o,
    output logic nap_o,
    output logic powered_down_o,
    output logic word_valid_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad_conv
        $error("conversion cycle count out of range");
    end
    if (INT_HALF < 1 || INT_HALF > 255) begin : g_bad_half
        $error("internal clock half period out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    sarlc_pkg::sarlc_pins_t pin_raw;
    sarlc_pkg::sarlc_pins_t pin_s1;
    sarlc_pkg::sarlc_pins_t pin_s2;
    sarlc_pkg::sarlc_pins_t pin_s3;

    assign pin_raw = '{
        conv_cmos_n: convert_start_cmos_n_i,
        conv_lvds_n: convert_start_lvds_n_i,
        cs_n: chip_select_n_i,
        byte_sel: byte_frame_sel_i,
        pd_n: power_down_n_i,
        nap_sel: nap_sel_i,
        cascade: topology_sel_i,
        clk_int: clock_source_sel_i,
        latency: read_latency_sel_i,
        rd_n: read_request_n_i,
        clk_drive: cascade_clock_drive_sel_i,
        ext_clk: ext_clock_i,
        chain_d: chain_data_in_i,
        chain_f: chain_frame_in_i
    };

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // unused start input is held low, so an or merges both cleanly
    logic conv_lvl;
    logic conv_old;
    logic conv_rise;
    logic conv_fall;
    logic rd_fall;
    assign conv_lvl = pin_s2.conv_cmos_n | pin_s2.conv_lvds_n;
    assign conv_old = pin_s3.conv_cmos_n | pin_s3.conv_lvds_n;
    assign conv_rise = conv_lvl & ~conv_old;
    assign conv_fall = ~conv_lvl & conv_old;
    assign rd_fall = ~pin_s2.rd_n & pin_s3.rd_n;

    ////////////////////////////////////////////////////////////////////////////////
    // i/o clock source

    logic [7:0] div_cnt;
    logic int_clk;
    logic src_lvl;
    logic src_prev;
    logic io_rise;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt <= 8'h00;
            int_clk <= 1'b0;
        end else if (div_cnt == 8'(INT_HALF - 1)) begin
            div_cnt <= 8'h00;
            int_clk <= ~int_clk;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // internal rate is a divided system clock, far below the nominal link rate
    assign src_lvl = pin_s2.clk_int ? int_clk : pin_s2.ext_clk;
    assign io_rise = src_lvl & ~src_prev;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_prev <= 1'b0;
            out_clock_o <= 1'b0;
        end else begin
            src_prev <= src_lvl;
            out_clock_o <= src_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sample and convert phases

    sarlc_pkg::sarlc_phase_t phase;
    logic [15:0] conv_cnt;
    logic pend_sample;
    logic conv_done;
    assign conv_done = (phase == sarlc_pkg::PH_CONV) && (conv_cnt == 16'h0000);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase <= sarlc_pkg::PH_DOWN;
            conv_cnt <= 16'h0000;
            pend_sample <= 1'b0;
        end else if (!pin_s2.pd_n) begin
            phase <= sarlc_pkg::PH_DOWN;
            pend_sample <= 1'b0;
        end else begin
            case (phase)
                sarlc_pkg::PH_DOWN: begin
                    phase <= sarlc_pkg::PH_WAIT;
                end
                sarlc_pkg::PH_WAIT, sarlc_pkg::PH_NAP: begin
                    if (conv_rise) begin
                        phase <= sarlc_pkg::PH_SAMPLE;
                    end
                end
                sarlc_pkg::PH_SAMPLE: begin
                    if (conv_fall) begin
                        phase <= sarlc_pkg::PH_CONV;
                        conv_cnt <= 16'(CONV_CYCLES - 1);
                    end
                end
                sarlc_pkg::PH_CONV: begin
                    if (conv_fall) begin
                        phase <= sarlc_pkg::PH_WAIT;
                        pend_sample <= 1'b0;
                    end else if (conv_done) begin
                        pend_sample <= 1'b0;
                        if (pend_sample || conv_rise) begin
                            phase <= sarlc_pkg::PH_SAMPLE;
                        end else if (pin_s2.nap_sel) begin
                            phase <= sarlc_pkg::PH_NAP;
                        end else begin
                            phase <= sarlc_pkg::PH_WAIT;
                        end
                    end else begin
                        conv_cnt <= conv_cnt - 16'h0001;
                        if (conv_rise) begin
                            pend_sample <= 1'b1;
                        end
                    end
                end
                default: begin
                    phase <= sarlc_pkg::PH_WAIT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // result words

    logic [`SARLC_WORD_BITS-1:0] last_word;
    logic [`SARLC_WORD_BITS-1:0] prev_word;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_word <= `SARLC_WORD_RESET;
            prev_word <= `SARLC_WORD_RESET;
            word_valid_o <= 1'b0;
        end else if (phase == sarlc_pkg::PH_CONV && conv_fall) begin
            word_valid_o <= 1'b0;
        end else if (conv_done) begin
            prev_word <= last_word;
            last_word <= sample_data_i;
            word_valid_o <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read cycle

    sarlc_pkg::sarlc_read_t rstate;
    logic [4:0] edge_cnt;
    logic [`SARLC_WORD_BITS-1:0] shift_word;
    logic read_ok;
    logic [4:0] bit_idx;
    assign read_ok = ~pin_s2.cs_n && (phase == sarlc_pkg::PH_WAIT
        || phase == sarlc_pkg::PH_SAMPLE || phase == sarlc_pkg::PH_NAP);
    assign bit_idx = `SARLC_LAST_EDGE - edge_cnt;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rstate <= sarlc_pkg::RD_IDLE;
            edge_cnt <= 5'h00;
            shift_word <= `SARLC_WORD_RESET;
            bus_in_use_o <= 1'b0;
            serial_data_out_o <= 1'b0;
            frame_sync_o <= 1'b0;
        end else if (pin_s2.cs_n || phase == sarlc_pkg::PH_DOWN) begin
            // floated outputs stay so until a new read begins
            rstate <= sarlc_pkg::RD_IDLE;
            bus_in_use_o <= 1'b0;
        end else begin
            case (rstate)
                sarlc_pkg::RD_IDLE: begin
                    if (rd_fall && read_ok) begin
                        rstate <= sarlc_pkg::RD_SEND;
                        bus_in_use_o <= 1'b1;
                        edge_cnt <= 5'h00;
                        shift_word <= pin_s2.latency ? prev_word : last_word;
                        serial_data_out_o <= 1'b0;
                        frame_sync_o <= 1'b0;
                    end
                end
                sarlc_pkg::RD_SEND: begin
                    if (io_rise) begin
                        if (edge_cnt == `SARLC_DONE_EDGE) begin
                            bus_in_use_o <= 1'b0;
                            frame_sync_o <= 1'b0;
                            rstate <= pin_s2.cascade ? sarlc_pkg::RD_IDLE
                                : sarlc_pkg::RD_FWD;
                        end else begin
                            edge_cnt <= edge_cnt + 5'h01;
                            // high for the first half of each frame slot
                            frame_sync_o <= pin_s2.byte_sel ? ~edge_cnt[2]
                                : ~edge_cnt[3];
                            if (edge_cnt >= `SARLC_MSB_EDGE) begin
                                serial_data_out_o <= shift_word[bit_idx[3:0]];
                            end
                        end
                    end
                end
                sarlc_pkg::RD_FWD: begin
                    if (pin_s2.rd_n) begin
                        rstate <= sarlc_pkg::RD_IDLE;
                    end else if (io_rise) begin
                        serial_data_out_o <= pin_s2.chain_d;
                        frame_sync_o <= pin_s2.chain_f;
                    end
                end
                default: begin
                    rstate <= sarlc_pkg::RD_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // drivers and status

    logic drive_bus;
    assign drive_bus = (rstate != sarlc_pkg::RD_IDLE);
    assign serial_data_out_oe_n_o = ~drive_bus;
    assign frame_sync_oe_n_o = ~drive_bus;
    // clock is left running under chip select high so the receiver keeps lock
    assign out_clock_oe_n_o = (phase == sarlc_pkg::PH_DOWN)
        || (pin_s2.cascade && ~pin_s2.clk_drive);
    assign busy_o = (phase == sarlc_pkg::PH_CONV);
    assign nap_o = (phase == sarlc_pkg::PH_NAP);
    assign powered_down_o = (phase == sarlc_pkg::PH_DOWN);

endmodule // sarlc_ctrl

// >>> test/sarlc_ctrl_properties.sv
`timescale 1ns/1ns
module sarlc_ctrl_properties #(
    parameter int unsigned CONV_CYCLES = 50,
    parameter int unsigned INT_HALF = 1
) (
    input logic sys_clk_i,
    input logic rst_n_i,
    input logic chip_select_n_i,
    input logic power_down_n_i,
    input logic topology_sel_i,
    input logic cascade_clock_drive_sel_i,
    input logic serial_data_out_o,
    input logic serial_data_out_oe_n_o,
    input logic frame_sync_o,
    input logic frame_sync_oe_n_o,
    input logic out_clock_o,
    input logic out_clock_oe_n_o,
    input logic busy_o,
    input logic bus_in_use_o,
    input logic nap_o,
    input logic powered_down_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [15:0] busy_cnt;
    logic [4:0] rise_cnt;
    logic clk_d;
    ////////////////////////////////////////////////////////////////////////////////
    // own counts, so a design counter off by one cannot hide
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_cnt <= 16'h0000;
        end else begin
            busy_cnt <= busy_o ? busy_cnt + 16'h0001 : 16'h0000;
        end
    end
    // rises counted only from the first sync-high rise of a word
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_d <= 1'b0;
            rise_cnt <= 5'h00;
        end else begin
            clk_d <= out_clock_o;
            if (!bus_in_use_o) begin
                rise_cnt <= 5'h00;
            end else if (out_clock_o && !clk_d && (frame_sync_o || rise_cnt != 5'h00)) begin
                rise_cnt <= rise_cnt + 5'h01;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    conv_len_a: assert property (busy_o |-> busy_cnt < CONV_CYCLES)
        else $error("busy held past conversion time");
    cs_float_a: assert property (chip_select_n_i [*5] |-> serial_data_out_oe_n_o && frame_sync_oe_n_o)
        else $error("data or sync driven with chip select high");
    clk_kept_a: assert property ((power_down_n_i && (!topology_sel_i || cascade_clock_drive_sel_i)) [*7] |-> !out_clock_oe_n_o)
        else $error("output clock not driven");
    clk_float_a: assert property ((topology_sel_i && !cascade_clock_drive_sel_i) [*5] |-> out_clock_oe_n_o)
        else $error("output clock driven in cascade with drive off");
    pd_enter_a: assert property (!power_down_n_i [*5] |-> powered_down_o && !busy_o)
        else $error("no power-down with input low");
    pd_leave_a: assert property (power_down_n_i [*8] |-> !powered_down_o)
        else $error("still powered down with input high");
    sdo_edge_a: assert property (bus_in_use_o && $past(bus_in_use_o) && $changed(serial_data_out_o) |-> $rose(out_clock_o))
        else $error("data moved off a clock rise");
    sync_edge_a: assert property (bus_in_use_o && $past(bus_in_use_o) && $changed(frame_sync_o) |-> $rose(out_clock_o))
        else $error("sync moved off a clock rise");
    word_len_a: assert property ($fell(bus_in_use_o) && !powered_down_o |-> rise_cnt == 5'h12)
        else $error("bus released after wrong rise count");
    nap_entry_a: assert property ($rose(nap_o) |-> $past(busy_o))
        else $error("nap entered not at conversion end");
    read_start_a: assert property ($rose(bus_in_use_o) |-> !serial_data_out_oe_n_o && !frame_sync_oe_n_o && !busy_o)
        else $error("read start without outputs enabled");
    word_cov: cover property ($fell(bus_in_use_o));
    nap_cov: cover property ($rose(nap_o));
    casc_cov: cover property (topology_sel_i && $rose(bus_in_use_o));
endmodule // sarlc_ctrl_properties
bind sarlc_ctrl sarlc_ctrl_properties #(.CONV_CYCLES(CONV_CYCLES), .INT_HALF(INT_HALF))
    sarlc_ctrl_properties_inst (.sys_clk_i, .rst_n_i, .chip_select_n_i, .power_down_n_i,
    .topology_sel_i, .cascade_clock_drive_sel_i, .serial_data_out_o, .serial_data_out_oe_n_o,
    .frame_sync_o, .frame_sync_oe_n_o, .out_clock_o, .out_clock_oe_n_o, .busy_o,
    .bus_in_use_o, .nap_o, .powered_down_o);

// >>> test/sarlc_rx_model.sv
`timescale 1ns/1ns
module sarlc_rx_model (
    input logic sys_clk_i,
    input logic rst_n_i,
    input logic clk_i,
    input logic sync_i,
    input logic data_i,
    output logic [16:0] word_o,
    output logic stb_o
);
    logic pclk, psync, act;
    logic [4:0] n;
    logic [15:0] sh;
    // word_o[16] holds sync at rise 8: high only in byte frames
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {pclk, psync, act, n, sh, word_o, stb_o} <= '0;
        end else begin
            pclk <= clk_i;
            stb_o <= 1'b0;
            if (clk_i && !pclk) begin
                psync <= sync_i;
                n <= n + 5'h01;
                if (sync_i && !psync && !act) begin
                    n <= 5'h00;
                    act <= 1'b1;
                end
                if (n == 5'h07) word_o[16] <= sync_i;
            end
            if (!clk_i && pclk && act && n >= 5'h02 && n <= 5'h11) begin
                sh <= {sh[14:0], data_i};
                if (n == 5'h11) begin
                    word_o[15:0] <= {sh[14:0], data_i};
                    stb_o <= 1'b1;
                    act <= 1'b0;
                end
            end
        end
    end
endmodule // sarlc_rx_model

// >>> test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic sys_clk_i, rst_n_i, ext_clock_i, convert_start_cmos_n_i, convert_start_lvds_n_i;
    logic chip_select_n_i, byte_frame_sel_i, power_down_n_i, nap_sel_i, topology_sel_i;
    logic clock_source_sel_i, read_latency_sel_i, read_request_n_i, cascade_clock_drive_sel_i;
    logic chain_data_in_i, chain_frame_in_i, serial_data_out_o, serial_data_out_oe_n_o;
    logic frame_sync_o, frame_sync_oe_n_o, out_clock_o, out_clock_oe_n_o, busy_o;
    logic bus_in_use_o, nap_o, powered_down_o, word_valid_o, rx_stb;
    logic [15:0] sample_data_i, seed, prv, lst;
    logic [16:0] rx_word, q[$];
    int err_total = 0, tests_run = 0, tnum = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    always begin
        #62 ext_clock_i = ~ext_clock_i;
        #63 ext_clock_i = ~ext_clock_i;
    end
    sarlc_ctrl #(.CONV_CYCLES(8), .INT_HALF(1)) sarlc_ctrl_inst (.sys_clk_i, .rst_n_i,
        .convert_start_cmos_n_i, .convert_start_lvds_n_i, .chip_select_n_i, .byte_frame_sel_i,
        .power_down_n_i, .nap_sel_i, .topology_sel_i, .clock_source_sel_i, .read_latency_sel_i,
        .read_request_n_i, .cascade_clock_drive_sel_i, .ext_clock_i, .chain_data_in_i,
        .chain_frame_in_i, .sample_data_i, .serial_data_out_o, .serial_data_out_oe_n_o,
        .frame_sync_o, .frame_sync_oe_n_o, .out_clock_o, .out_clock_oe_n_o, .busy_o,
        .bus_in_use_o, .nap_o, .powered_down_o, .word_valid_o);
    // receiver failsafe bias pulls a floated pair low
    sarlc_rx_model sarlc_rx_model_inst (.sys_clk_i, .rst_n_i, .word_o(rx_word), .stb_o(rx_stb),
        .clk_i(!out_clock_oe_n_o && out_clock_o), .sync_i(!frame_sync_oe_n_o && frame_sync_o),
        .data_i(!serial_data_out_oe_n_o && serial_data_out_o));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic tdone();
        tnum++;
        $display("test %0d done", tnum);
    endtask
    // bounded wait, sampled on the falling edge away from updates
    task automatic wait_for(ref logic s, input logic v);
        int i;
        for (i = 0; i < 3000 && s !== v; i++) @(negedge sys_clk_i);
        @(posedge sys_clk_i);
        if (i == 3000) begin
            err_total++;
            end_sim();
        end
    endtask
    task automatic probe(ref logic s, input logic e);
        @(negedge sys_clk_i);
        chk({16'h0000, s}, {16'h0000, e});
        @(posedge sys_clk_i);
    endtask
    task automatic convert(input logic lvds);
        seed = lfsr(seed);
        if (lvds) convert_start_lvds_n_i <= 1'b1;
        else convert_start_cmos_n_i <= 1'b1;
        cyc(6);
        sample_data_i <= seed;
        convert_start_cmos_n_i <= 1'b0;
        convert_start_lvds_n_i <= 1'b0;
        wait_for(busy_o, 1'b1);
        wait_for(busy_o, 1'b0);
        prv = lst;
        lst = seed;
        probe(word_valid_o, 1'b1);
    endtask
    task automatic read(input logic [16:0] exp);
        q.push_back(exp);
        read_request_n_i <= 1'b0;
        wait_for(bus_in_use_o, 1'b1);
        wait_for(bus_in_use_o, 1'b0);
        cyc(4);
        read_request_n_i <= 1'b1;
        cyc(6);
    endtask
    always @(negedge sys_clk_i) begin
        if (rx_stb === 1'b1) chk(rx_word, q.size() > 0 ? q.pop_front() : ~rx_word);
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {sys_clk_i, rst_n_i, ext_clock_i, convert_start_cmos_n_i, convert_start_lvds_n_i} = '0;
        {chip_select_n_i, byte_frame_sel_i, nap_sel_i, topology_sel_i, read_latency_sel_i} = '0;
        {cascade_clock_drive_sel_i, chain_data_in_i, chain_frame_in_i, prv, lst} = '0;
        {power_down_n_i, clock_source_sel_i, read_request_n_i} = '1;
        sample_data_i = '0;
        seed = 16'h0010;
        cyc(6);
        rst_n_i <= 1'b1;
        cyc(8);
        convert(1'b0);
        read({1'b0, lst});
        byte_frame_sel_i <= 1'b1;
        read({1'b1, lst});
        byte_frame_sel_i <= 1'b0;
        tdone();
        read_latency_sel_i <= 1'b1;
        convert(1'b0);
        read({1'b0, prv});
        read_latency_sel_i <= 1'b0;
        convert(1'b1);
        read({1'b0, lst});
        clock_source_sel_i <= 1'b0;
        read({1'b0, lst});
        clock_source_sel_i <= 1'b1;
        tdone();
        // previous chained device: data high, its sync kept low so no frame starts
        chain_data_in_i <= 1'b1;
        chain_frame_in_i <= 1'b0;
        q.push_back({1'b0, lst});
        read_request_n_i <= 1'b0;
        wait_for(bus_in_use_o, 1'b1);
        wait_for(bus_in_use_o, 1'b0);
        cyc(4);
        probe(serial_data_out_o, 1'b1);
        probe(serial_data_out_oe_n_o, 1'b0);
        chip_select_n_i <= 1'b1;
        cyc(6);
        probe(serial_data_out_oe_n_o, 1'b1);
        probe(frame_sync_oe_n_o, 1'b1);
        probe(out_clock_oe_n_o, 1'b0);
        chain_data_in_i <= 1'b0;
        read_request_n_i <= 1'b1;
        cyc(6);
        read_request_n_i <= 1'b0;
        cyc(60);
        probe(bus_in_use_o, 1'b0);
        read_request_n_i <= 1'b1;
        chip_select_n_i <= 1'b0;
        cyc(6);
        convert_start_cmos_n_i <= 1'b1;
        cyc(6);
        convert_start_cmos_n_i <= 1'b0;
        wait_for(busy_o, 1'b1);
        convert_start_cmos_n_i <= 1'b1;
        cyc(1);
        convert_start_cmos_n_i <= 1'b0;
        wait_for(busy_o, 1'b0);
        probe(word_valid_o, 1'b0);
        tdone();
        nap_sel_i <= 1'b1;
        convert(1'b0);
        probe(nap_o, 1'b1);
        read({1'b0, lst});
        convert_start_cmos_n_i <= 1'b1;
        cyc(6);
        probe(nap_o, 1'b0);
        convert_start_cmos_n_i <= 1'b0;
        wait_for(busy_o, 1'b1);
        convert_start_cmos_n_i <= 1'b1;
        wait_for(busy_o, 1'b0);
        probe(nap_o, 1'b0);
        convert_start_cmos_n_i <= 1'b0;
        wait_for(busy_o, 1'b1);
        wait_for(busy_o, 1'b0);
        nap_sel_i <= 1'b0;
        topology_sel_i <= 1'b1;
        cyc(6);
        probe(out_clock_oe_n_o, 1'b1);
        cascade_clock_drive_sel_i <= 1'b1;
        cyc(6);
        probe(out_clock_oe_n_o, 1'b0);
        read({1'b0, lst});
        probe(serial_data_out_oe_n_o, 1'b1);
        topology_sel_i <= 1'b0;
        tdone();
        power_down_n_i <= 1'b0;
        cyc(6);
        probe(powered_down_o, 1'b1);
        probe(out_clock_oe_n_o, 1'b1);
        power_down_n_i <= 1'b1;
        cyc(8);
        probe(powered_down_o, 1'b0);
        tdone();
        chk(17'(q.size()), 17'h0_0000);
        end_sim();
    end
endmodule // tb_top
